// ---- logic/rcsm_lock_check.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcsm_lock_check #(
	parameter int CW = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Edge pulses of reference and feedback
	input wire logic ref_edge,
	input wire logic fb_edge,
	// Lock state
	output logic locked
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] period_r;
	logic fb_seen_r;
	logic [CW-1:0] half;
	logic in_win;

	// Feedback edge within half a period of the reference edge on either side
	assign half = period_r >> 1;
	assign in_win = (cnt_r <= half) || ((period_r - cnt_r) <= half);

	// Phase counter and reference period measurement
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			period_r <= '0;
		end else if (ref_edge) begin
			cnt_r <= '0;
			period_r <= cnt_r + 1'b1;
		end else if (cnt_r != {CW{1'b1}}) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Lock decision at each feedback edge, lost when a period has none
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fb_seen_r <= 1'b0;
			locked <= 1'b0;
		end else if (ref_edge) begin
			fb_seen_r <= fb_edge;
			// Coincident edges are in phase; a period with no feedback loses lock
			if (fb_edge) begin
				locked <= 1'b1;
			end else if (!fb_seen_r) begin
				locked <= 1'b0;
			end
		end else if (fb_edge) begin
			fb_seen_r <= 1'b1;
			locked <= in_win;
		end
	end
endmodule : rcsm_lock_check
`default_nettype wire

// ---- logic/rcsm_pkg.sv ----
`default_nettype none
package rcsm_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_SRC = 8'h08;
	localparam logic [7:0] REG_OUT = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_DIV0 = 8'h20;
	localparam int NDIV = 5;
	// Control register fields
	localparam int CTRL_ARR = 0;
	localparam int CTRL_SM_LO = 1;
	localparam int CTRL_PRIM = 3;
	localparam int CTRL_OKC = 4;
	localparam int CTRL_EN_LO = 8;
	localparam logic [31:0] CTRL_RST = 32'h00003F00;
	// Configuration register fields
	localparam int CFG_PWR_LO = 12;
	localparam logic [31:0] CFG_RST = 32'h00007000;
	// Bank source field codes, three bits per bank
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_INPUT = 3'h4;
	localparam logic [31:0] SRC_RST = 32'h00000004;
	// Output register fields
	localparam int OUT_LVL_LO = 6;
	localparam int OUT_PM_LO = 10;
	localparam logic [31:0] OUT_RST = 32'h00007C00;
	// Divider register fields
	localparam int DIV_SET1_LO = 16;
	localparam logic [31:0] DIV_RST = 32'h00010001;
	// Switchover mode codes
	localparam logic [1:0] SM_NONREV = 2'h2;
	localparam logic [1:0] SM_REV = 2'h3;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int REF_LOST_NS = 1000;
	localparam int REF_LOST_CYC = (REF_LOST_NS * CLK_MHZ) / 1000;
	localparam int MISS_EDGES = 2;
	localparam int HOLD_EDGES = 2;
	localparam int REVERT_SHORT = 8;
	localparam int REVERT_LONG = 1024;
	// Switchover states
	typedef enum logic [0:0] {
		SW_PRI = 1'b0,
		SW_SEC = 1'b1
	} rcsm_sw_t;
endpackage : rcsm_pkg
`default_nettype wire

// ---- logic/rcsm_post_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcsm_post_div #(
	parameter int DW = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Source level, power and ratio
	input wire logic src,
	input wire logic pwr,
	input wire logic [DW-1:0] ratio,
	// Divided level
	output logic out
);
	logic src_q;
	logic [DW-1:0] cnt_r;

	// Toggle the output every ratio source edges, ratio zero or power off parks low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= 1'b0;
			cnt_r <= '0;
			out <= 1'b0;
		end else begin
			src_q <= src;
			if (!pwr || ratio == '0) begin
				cnt_r <= '0;
				out <= 1'b0;
			end else if (src && !src_q) begin
				if (cnt_r + 1'b1 >= ratio) begin
					cnt_r <= '0;
					out <= ~out;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	end
endmodule : rcsm_post_div
`default_nettype wire

// ---- logic/rcsm_top.sv ----
// Added by the designer: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rcsm_top #(
	parameter int NBANK = 6,
	parameter int DW = 10
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Reference inputs and select pins
	input wire logic crystal_reference_input,
	input wire logic second_reference_input,
	input wire logic clk_sel_pin,
	input wire logic prog_mode,
	input wire logic [5:0] select_input,
	// PLL clocks
	input wire logic [2:0] pll_out,
	input wire logic [2:0] pll_ref_clk,
	input wire logic [2:0] pll_fb_clk,
	// Configuration selection
	output logic [2:0] pll0_cfg,
	output logic [1:0] pll1_cfg,
	output logic [1:0] pll2_cfg,
	output logic [2:0] divider_set_pick,
	// Banks and flags
	output logic sel_ref_clk,
	output logic [NBANK-1:0] bank_clk,
	output logic [3:0] bank_level_select,
	output logic lock_lost_flag,
	output logic input_clock_lost_flag
);
	logic [31:0] ctrl_r, cfg_r, src_r, out_r;
	logic [31:0] div_r [rcsm_pkg::NDIV];
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic addr_ok;
	logic [31:0] rd_nxt;
	logic [4:0] gin_latch_r;
	logic latched_r;
	logic [5:0] gin_eff;
	logic ra_q, rb_q;
	logic [2:0] pr_q, pf_q, lck;
	logic [1:0] edge_ab;
	logic [$clog2(rcsm_pkg::REF_LOST_CYC+1)-1:0] lost_cnt_r [2];
	logic [1:0] lost;
	logic prim, pe, se, pri_lost, sec_lost, both_lost, auto_on;
	logic [1:0] sm;
	rcsm_pkg::rcsm_sw_t sw_r;
	logic [1:0] miss_r;
	logic [10:0] good_r;
	logic [10:0] thr;
	logic sel_q_r, sel_toggle;
	logic sel_app_r, app_ok, new_edge;
	logic [1:0] hold_r, in_hold_r;
	logic auto_lost_r;
	logic [2:0] bank_src [NBANK];
	logic [NBANK-1:0] src_lvl, div_lvl;

	// Bus slave answers in zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && hready && htrans[1];

	// Read data for the address phase, registered into the data phase
	always_comb begin
		rd_nxt = 32'h00000000;
		case (haddr[7:0])
			rcsm_pkg::REG_CTRL: rd_nxt = ctrl_r;
			rcsm_pkg::REG_CFG: rd_nxt = cfg_r;
			rcsm_pkg::REG_SRC: rd_nxt = src_r;
			rcsm_pkg::REG_OUT: rd_nxt = out_r;
			rcsm_pkg::REG_STAT: rd_nxt = {25'h0000000, sel_app_r, sw_r, lck, input_clock_lost_flag,
				lock_lost_flag};
			default: begin
				for (int k = 0; k < rcsm_pkg::NDIV; k++) begin
					if (haddr[7:0] == rcsm_pkg::REG_DIV0 + 8'(4 * k)) begin
						rd_nxt = div_r[k];
					end
				end
			end
		endcase
	end

	// Address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h00000000;
		end else if (hready) begin
			wr_pend_r <= addr_ok && hwrite && hsize == 3'h2;
			wr_addr_r <= haddr[7:0];
			hrdata <= addr_ok && !hwrite ? rd_nxt : 32'h00000000;
		end
	end

	// Register writes; only the power-on reset clears them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= rcsm_pkg::CTRL_RST;
			cfg_r <= rcsm_pkg::CFG_RST;
			src_r <= rcsm_pkg::SRC_RST;
			out_r <= rcsm_pkg::OUT_RST;
			for (int k = 0; k < rcsm_pkg::NDIV; k++) begin
				div_r[k] <= rcsm_pkg::DIV_RST;
			end
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				rcsm_pkg::REG_CTRL: ctrl_r <= hwdata & 32'h00003F1F;
				rcsm_pkg::REG_CFG: cfg_r <= hwdata & 32'h00007FFF;
				rcsm_pkg::REG_SRC: src_r <= hwdata & 32'h0003FFFF;
				rcsm_pkg::REG_OUT: out_r <= hwdata & 32'h00007FFF;
				default: begin
					for (int k = 0; k < rcsm_pkg::NDIV; k++) begin
						if (wr_addr_r == rcsm_pkg::REG_DIV0 + 8'(4 * k)) begin
							div_r[k] <= hwdata & 32'h03FF03FF;
						end
					end
				end
			endcase
		end
	end

	// Catch inputs 4-0 once after reset release, enables ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latched_r <= 1'b0;
			gin_latch_r <= 5'h00;
		end else if (!latched_r) begin
			latched_r <= 1'b1;
			gin_latch_r <= select_input[4:0];
		end
	end

	// Effective select inputs, input 5 low while programming
	assign gin_eff = prog_mode ? {1'b0, gin_latch_r} :
		select_input & ctrl_r[rcsm_pkg::CTRL_EN_LO +: 6];

	// Configuration choice and divider-set bit per PLL
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pll0_cfg <= 3'h0;
			pll1_cfg <= 2'h0;
			pll2_cfg <= 2'h0;
			divider_set_pick <= 3'h0;
		end else if (ctrl_r[rcsm_pkg::CTRL_ARR]) begin
			pll0_cfg <= gin_eff[2:0];
			pll1_cfg <= 2'h0;
			pll2_cfg <= 2'h0;
			// Configs 4,5 borrow PLL1 slots, 6,7 borrow PLL2 slots
			divider_set_pick <= {cfg_r[8], cfg_r[4], cfg_r[{gin_eff[2] & gin_eff[1],
				gin_eff[2] & ~gin_eff[1], ~gin_eff[2] & gin_eff[1], gin_eff[0]}]};
		end else begin
			pll0_cfg <= {1'b0, gin_eff[1:0]};
			pll1_cfg <= gin_eff[3:2];
			pll2_cfg <= gin_eff[5:4];
			divider_set_pick <= {cfg_r[{2'h2, gin_eff[5:4]}], cfg_r[{2'h1, gin_eff[3:2]}],
				cfg_r[{2'h0, gin_eff[1:0]}]};
		end
	end

	// Sampled levels of references and PLL clocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ra_q <= 1'b0;
			rb_q <= 1'b0;
			pr_q <= 3'h0;
			pf_q <= 3'h0;
		end else begin
			ra_q <= crystal_reference_input;
			rb_q <= second_reference_input;
			pr_q <= pll_ref_clk;
			pf_q <= pll_fb_clk;
		end
	end

	// Lock checkers, one per PLL
	for (genvar p = 0; p < 3; p++) begin : g_lock
		rcsm_lock_check #(.CW(12)) u_lock (
			.clk(hclk),
			.rst_n(hresetn),
			.ref_edge(pll_ref_clk[p] && !pr_q[p]),
			.fb_edge(pll_fb_clk[p] && !pf_q[p]),
			.locked(lck[p])
		);
	end

	// Absence timers run from the internal clock, so no reference is needed
	assign edge_ab = {second_reference_input && !rb_q, crystal_reference_input && !ra_q};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lost_cnt_r[0] <= '0;
			lost_cnt_r[1] <= '0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (edge_ab[i]) begin
					lost_cnt_r[i] <= '0;
				end else if (!lost[i]) begin
					lost_cnt_r[i] <= lost_cnt_r[i] + 1'b1;
				end
			end
		end
	end
	assign lost[0] = lost_cnt_r[0] == ($bits(lost_cnt_r[0]))'(rcsm_pkg::REF_LOST_CYC);
	assign lost[1] = lost_cnt_r[1] == ($bits(lost_cnt_r[1]))'(rcsm_pkg::REF_LOST_CYC);

	// Primary and secondary roles from the pick bit
	assign prim = ctrl_r[rcsm_pkg::CTRL_PRIM];
	assign pe = prim ? edge_ab[1] : edge_ab[0];
	assign se = prim ? edge_ab[0] : edge_ab[1];
	assign pri_lost = prim ? lost[1] : lost[0];
	assign sec_lost = prim ? lost[0] : lost[1];
	assign both_lost = &lost;
	assign sm = ctrl_r[rcsm_pkg::CTRL_SM_LO +: 2];
	// Automatic only with the crystal input as primary
	assign auto_on = sm[1] && !prim;
	assign thr = ctrl_r[rcsm_pkg::CTRL_OKC] ? 11'(rcsm_pkg::REVERT_LONG) :
		11'(rcsm_pkg::REVERT_SHORT);

	// Select pin toggle detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_q_r <= 1'b0;
		end else begin
			sel_q_r <= clk_sel_pin;
		end
	end
	assign sel_toggle = clk_sel_pin != sel_q_r;

	// Switchover state; misses counted on secondary edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_r <= rcsm_pkg::SW_PRI;
			miss_r <= 2'h0;
			good_r <= 11'h000;
		end else if (!auto_on) begin
			sw_r <= clk_sel_pin ? rcsm_pkg::SW_SEC : rcsm_pkg::SW_PRI;
			miss_r <= 2'h0;
			good_r <= 11'h000;
		end else begin
			case (sw_r)
				rcsm_pkg::SW_PRI: begin
					good_r <= 11'h000;
					if (pe) begin
						miss_r <= 2'h0;
					end else if (se) begin
						if (miss_r == 2'(rcsm_pkg::MISS_EDGES - 1)) begin
							sw_r <= rcsm_pkg::SW_SEC;
							miss_r <= 2'h0;
						end else begin
							miss_r <= miss_r + 2'h1;
						end
					end
				end
				rcsm_pkg::SW_SEC: begin
					miss_r <= 2'h0;
					if (sm == rcsm_pkg::SM_NONREV) begin
						// Stays on secondary until the select pin toggles
						if (sel_toggle) begin
							sw_r <= rcsm_pkg::SW_PRI;
						end
					end else if (pri_lost) begin
						good_r <= 11'h000;
					end else if (pe) begin
						if (good_r == thr - 11'h001) begin
							sw_r <= rcsm_pkg::SW_PRI;
							good_r <= 11'h000;
						end else begin
							good_r <= good_r + 11'h001;
						end
					end
				end
				default: sw_r <= rcsm_pkg::SW_PRI;
			endcase
		end
	end

	// Applied select moves only while both inputs are low or the old one is gone
	assign app_ok = (!ra_q && !rb_q) || (sel_app_r ? sec_lost : pri_lost);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_app_r <= 1'b0;
			sel_ref_clk <= 1'b0;
		end else begin
			if (app_ok) begin
				sel_app_r <= sw_r == rcsm_pkg::SW_SEC;
			end
			sel_ref_clk <= sel_app_r ? (prim ? ra_q : rb_q) : (prim ? rb_q : ra_q);
		end
	end
	assign new_edge = sel_app_r ? se : pe;

	// Loss holds: lock-loss per switch, input-loss after an automatic switch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_r <= 2'h0;
			in_hold_r <= 2'h0;
			auto_lost_r <= 1'b0;
		end else begin
			if (app_ok && sel_app_r != (sw_r == rcsm_pkg::SW_SEC)) begin
				// One spare edge: the first new edge may come before the flag shows
				hold_r <= 2'(rcsm_pkg::HOLD_EDGES + 1);
			end else if (hold_r != 2'h0 && new_edge) begin
				hold_r <= hold_r - 2'h1;
			end
			if (auto_on && sw_r == rcsm_pkg::SW_PRI && se && !pe &&
				miss_r == 2'(rcsm_pkg::MISS_EDGES - 1)) begin
				in_hold_r <= 2'(rcsm_pkg::HOLD_EDGES);
				auto_lost_r <= sm == rcsm_pkg::SM_REV;
			end else begin
				if (in_hold_r != 2'h0 && se) begin
					in_hold_r <= in_hold_r - 2'h1;
				end
				// Revertive mode keeps the flag until the primary is back
				if (!auto_on || sw_r == rcsm_pkg::SW_PRI) begin
					auto_lost_r <= 1'b0;
				end
			end
		end
	end

	// Flags from powered PLLs, switch holds and absent inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_lost_flag <= 1'b0;
			input_clock_lost_flag <= 1'b0;
		end else begin
			lock_lost_flag <= |(~lck & cfg_r[rcsm_pkg::CFG_PWR_LO +: 3]) ||
				hold_r != 2'h0 || both_lost ||
				in_hold_r != 2'h0;
			input_clock_lost_flag <= (sel_app_r ? sec_lost : pri_lost) || both_lost ||
				in_hold_r != 2'h0 || auto_lost_r;
		end
	end

	// Bank routing, post-dividers and inversion
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		assign bank_src[b] = src_r[3 * b +: 3];
		assign src_lvl[b] = bank_src[b] == rcsm_pkg::SRC_INPUT ? sel_ref_clk :
			(bank_src[b] == rcsm_pkg::SRC_OFF || bank_src[b] > 3'h4) ? 1'b0 :
			pll_out[bank_src[b][1:0] - 2'h1];
		if (b == 0) begin : g_nodiv
			assign div_lvl[b] = src_lvl[b];
		end else begin : g_div
			logic pick;
			assign pick = (bank_src[b] >= 3'h1 && bank_src[b] <= 3'h3) ?
				divider_set_pick[bank_src[b][1:0] - 2'h1] : 1'b0;
			rcsm_post_div #(.DW(DW)) u_div (
				.clk(hclk),
				.rst_n(hresetn),
				.src(src_lvl[b]),
				.pwr(out_r[rcsm_pkg::OUT_PM_LO + b - 1]),
				.ratio(pick ? div_r[b-1][rcsm_pkg::DIV_SET1_LO +: DW] : div_r[b-1][DW-1:0]),
				.out(div_lvl[b])
			);
		end
	end
	// Registered bank outputs with inversion and level selects
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bank_clk <= '0;
			bank_level_select <= 4'h0;
		end else begin
			bank_clk <= div_lvl ^ out_r[NBANK-1:0];
			bank_level_select <= out_r[rcsm_pkg::OUT_LVL_LO +: 4];
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_switch;
		$changed(sel_app_r);
	endsequence
	sequence s_two_misses;
		auto_on && sw_r == rcsm_pkg::SW_PRI && se && !pe && miss_r == 2'h1;
	endsequence

	chk_switch_hold: assert property (s_switch |=> lock_lost_flag [*2])
		else $error("lock-loss not held after source change");
	chk_both_absent: assert property (both_lost |=> lock_lost_flag && input_clock_lost_flag)
		else $error("both flags not set with no inputs");
	chk_auto_switch: assert property (s_two_misses |=> sw_r == rcsm_pkg::SW_SEC ##1 input_clock_lost_flag)
		else $error("no switch to secondary after two misses");
	chk_manual_follow: assert property (!auto_on |=> sw_r == rcsm_pkg::rcsm_sw_t'($past(clk_sel_pin)))
		else $error("manual select not followed");
	chk_glitch_free: assert property (s_switch |-> $past(app_ok))
		else $error("select applied while a clock was high");
	chk_revert_count: assert property (auto_on && sm == rcsm_pkg::SM_REV && sw_r == rcsm_pkg::SW_SEC &&
		!pri_lost && pe && good_r == thr - 11'h001 |=> sw_r == rcsm_pkg::SW_PRI)
		else $error("no revert at threshold");
	chk_nonrev_stay: assert property (auto_on && sm == rcsm_pkg::SM_NONREV && sw_r == rcsm_pkg::SW_SEC &&
		!sel_toggle ##1 auto_on && sm == rcsm_pkg::SM_NONREV |-> sw_r == rcsm_pkg::SW_SEC)
		else $error("non-revertive left secondary");
	chk_lock_gate: assert property (&(lck | ~cfg_r[rcsm_pkg::CFG_PWR_LO +: 3]) && hold_r == 2'h0 &&
		!both_lost && in_hold_r == 2'h0 |=> !lock_lost_flag)
		else $error("lock-loss from an unpowered PLL");
	chk_arr_one: assert property (ctrl_r[rcsm_pkg::CTRL_ARR] |=> pll0_cfg == $past(gin_eff[2:0]))
		else $error("eight-way selection wrong");
	chk_arr_zero: assert property (!ctrl_r[rcsm_pkg::CTRL_ARR] |=> pll2_cfg == $past(gin_eff[5:4]))
		else $error("four-way selection wrong");
endmodule : rcsm_top
`default_nettype wire

// ---- testbench/rcsm_ref_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module rcsm_ref_src #(
	parameter int HALF = 5
) (
	// Clock and run enables
	input wire logic hclk,
	input wire logic run_a,
	input wire logic run_b,
	// Reference levels
	output logic ref_a,
	output logic ref_b
);
	int cnt = 0;
	initial ref_a = 1'b0;
	initial ref_b = 1'b0;
	// One shared rate, offset phase; a stopped source freezes its level
	always @(posedge hclk) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1 && run_a)
			ref_a <= ~ref_a;
		if (cnt == 2 && run_b)
			ref_b <= ~ref_b;
	end
endmodule : rcsm_ref_src
`default_nettype wire

// ---- testbench/tb_ref_clock_switchover_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ref_clock_switchover_monitor;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic clk_sel_pin = 1'b0;
	logic prog_mode = 1'b1;
	logic [5:0] select_input = 6'h3F;
	logic [2:0] pll_ref = 3'h0;
	logic [2:0] pll_fb = 3'h0;
	logic [2:0] fb_stop = 3'h0;
	logic run_a = 1'b1;
	logic run_b = 1'b1;
	logic prev_b = 1'b0;
	logic [31:0] rd;
	wire logic ref_a, ref_b, hreadyout, hresp, sel_ref_clk, lock_lost_flag;
	wire logic input_clock_lost_flag;
	wire logic [31:0] hrdata;
	wire logic [2:0] pll0_cfg, divider_set_pick;
	wire logic [1:0] pll1_cfg, pll2_cfg;
	wire logic [5:0] bank_clk;
	wire logic [3:0] bank_level_select;
	int num_errors = 0;
	int num_checks = 0;
	int hi_edges = 0;
	int last_edges = 0;

	always #4 hclk = ~hclk;

	rcsm_ref_src rcsm_ref_src_i (.hclk(hclk), .run_a(run_a), .run_b(run_b), .ref_a(ref_a),
		.ref_b(ref_b));

	rcsm_top rcsm_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crystal_reference_input(ref_a),
		.second_reference_input(ref_b), .clk_sel_pin(clk_sel_pin), .prog_mode(prog_mode),
		.select_input(select_input), .pll_out(pll_ref), .pll_ref_clk(pll_ref),
		.pll_fb_clk(pll_fb), .pll0_cfg(pll0_cfg), .pll1_cfg(pll1_cfg), .pll2_cfg(pll2_cfg),
		.divider_set_pick(divider_set_pick), .sel_ref_clk(sel_ref_clk), .bank_clk(bank_clk),
		.bank_level_select(bank_level_select), .lock_lost_flag(lock_lost_flag),
		.input_clock_lost_flag(input_clock_lost_flag));

	// Emulated PLLs track the selected reference; feedback can be stopped
	always @(posedge hclk) begin
		pll_ref <= {3{sel_ref_clk}};
		pll_fb <= {3{sel_ref_clk}} & ~fb_stop;
	end

	// Longest run of secondary edges under lock-loss while the select pin is high
	always @(posedge hclk) begin
		prev_b <= ref_b;
		if (!lock_lost_flag)
			hi_edges <= 0;
		else if (ref_b && !prev_b)
			hi_edges <= hi_edges + 1;
		if (clk_sel_pin && hi_edges > last_edges)
			last_edges <= hi_edges;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	// Waits for hready with a bound
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			chk(32'h0, 32'h1, "hready timeout");
			close_out();
		end
	endtask : rdy

	// One AHB-Lite single word transfer; read data lands in rd
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask : xfer

	// Polls a status bit until it reads v, bounded in reads
	task automatic wst(input int i, input logic v, input int b, input string m);
		int n;
		n = 0;
		xfer(32'(rcsm_pkg::REG_STAT), 1'b0, 32'h0);
		while (rd[i] !== v && n < b) begin
			xfer(32'(rcsm_pkg::REG_STAT), 1'b0, 32'h0);
			n++;
		end
		chk(32'(rd[i]), 32'(v), m);
		if (rd[i] !== v)
			close_out();
	endtask : wst

	// Counts level changes of one bank over n cycles
	task automatic tog(input int b, input int n, output int c);
		logic p;
		c = 0;
		p = bank_clk[b];
		repeat (n) begin
			@(posedge hclk);
			if (bank_clk[b] !== p)
				c++;
			p = bank_clk[b];
		end
	endtask : tog

	initial begin
		logic [7:0] ra [6];
		logic [31:0] rv [6];
		int c;
		ra = '{rcsm_pkg::REG_CTRL, rcsm_pkg::REG_CFG, rcsm_pkg::REG_SRC, rcsm_pkg::REG_OUT,
			rcsm_pkg::REG_DIV0, 8'h40};
		rv = '{rcsm_pkg::CTRL_RST, rcsm_pkg::CFG_RST, rcsm_pkg::SRC_RST, rcsm_pkg::OUT_RST,
			rcsm_pkg::DIV_RST, 32'h0};
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values, unmapped place ignores writes and reads zero
		xfer(32'h40, 1'b1, 32'hFFFFFFFF);
		foreach (ra[k]) begin
			xfer(32'(ra[k]), 1'b0, 32'h0);
			chk(rd, rv[k], "reset value");
		end
		chk(32'(hresp), 32'h0, "okay response");
		chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h3D, "latched select");
		select_input <= 6'h00;
		repeat (4) @(posedge hclk);
		chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h3D, "latched held");
		prog_mode <= 1'b0;
		select_input <= 6'h39;
		repeat (4) @(posedge hclk);
		chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h1B, "two pins per pll");
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST | 32'h1);
		select_input <= 6'h06;
		repeat (4) @(posedge hclk);
		chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h60, "eight configs");
		xfer(32'(rcsm_pkg::REG_CFG), 1'b1, rcsm_pkg::CFG_RST | 32'h20);
		select_input <= 6'h05;
		repeat (4) @(posedge hclk);
		chk(32'(divider_set_pick), 32'h1, "borrowed divider set");
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST);
		xfer(32'(rcsm_pkg::REG_CFG), 1'b1, rcsm_pkg::CFG_RST | 32'h4);
		select_input <= 6'h02;
		repeat (4) @(posedge hclk);
		chk(32'(divider_set_pick), 32'h1, "divider set on");
		select_input <= 6'h00;
		repeat (4) @(posedge hclk);
		chk(32'(divider_set_pick), 32'h0, "divider set off");
		$display("test config done");
		// Manual switch to secondary and back
		clk_sel_pin <= 1'b1;
		wst(6, 1'b1, 50, "manual to secondary");
		wst(0, 1'b0, 200, "relock");
		chk(32'(last_edges >= 2), 32'h1, "lock-loss two new edges");
		clk_sel_pin <= 1'b0;
		wst(6, 1'b0, 50, "manual to primary");
		// Second input as primary survives a stopped crystal
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST | 32'h8);
		run_a <= 1'b0;
		repeat (300) @(posedge hclk);
		chk(32'(input_clock_lost_flag), 32'h0, "second input primary");
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST);
		wst(1, 1'b1, 100, "selected lost");
		run_b <= 1'b0;
		wst(0, 1'b1, 100, "both lost lock flag");
		chk(32'(input_clock_lost_flag), 32'h1, "both lost input flag");
		run_a <= 1'b1;
		run_b <= 1'b1;
		wst(1, 1'b0, 200, "input back");
		wst(0, 1'b0, 200, "lock back");
		$display("test manual done");
		// Non-revertive automatic switching
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST | 32'h4);
		run_a <= 1'b0;
		wst(5, 1'b1, 100, "auto to secondary");
		wst(1, 1'b1, 10, "input flag");
		chk(32'(lock_lost_flag), 32'h1, "lock flag");
		run_a <= 1'b1;
		repeat (300) @(posedge hclk);
		wst(5, 1'b1, 1, "stays secondary");
		clk_sel_pin <= 1'b1;
		repeat (20) @(posedge hclk);
		clk_sel_pin <= 1'b0;
		wst(5, 1'b0, 100, "toggle returns");
		$display("test non-revertive done");
		// Revertive with both thresholds
		for (int t = 0; t < 2; t++) begin
			xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST | 32'h6 | 32'(t << 4));
			run_a <= 1'b0;
			wst(5, 1'b1, 100, "revert mode switch");
			run_a <= 1'b1;
			repeat (t ? 5000 : 40) @(posedge hclk);
			wst(5, 1'b1, 1, "not yet back");
			wst(5, 1'b0, t ? 4000 : 100, "reverted");
			wst(1, 1'b0, 20, "input flag cleared");
		end
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST);
		$display("test revertive done");
		// Lock loss from a powered PLL only
		fb_stop <= 3'h1;
		wst(0, 1'b1, 200, "feedback lost");
		xfer(32'(rcsm_pkg::REG_CFG), 1'b1, 32'h00006000);
		wst(0, 1'b0, 200, "shut PLL ignored");
		select_input <= 6'h3F;
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, 32'h0);
		repeat (4) @(posedge hclk);
		chk(32'(pll0_cfg), 32'h0, "disabled inputs low");
		fb_stop <= 3'h0;
		xfer(32'(rcsm_pkg::REG_CTRL), 1'b1, rcsm_pkg::CTRL_RST);
		xfer(32'(rcsm_pkg::REG_CFG), 1'b1, rcsm_pkg::CFG_RST);
		$display("test lock done");
		// Bank routing, levels and post-divide
		xfer(32'(rcsm_pkg::REG_OUT), 1'b1, rcsm_pkg::OUT_RST | 32'h280);
		repeat (4) @(posedge hclk);
		chk(32'(bank_level_select), 32'hA, "level select");
		tog(0, 200, c);
		chk(32'(c > 0), 32'h1, "bank 1 toggles");
		tog(1, 200, c);
		chk(32'(c), 32'h0, "bank 2 idle");
		xfer(32'(rcsm_pkg::REG_SRC), 1'b1, rcsm_pkg::SRC_RST | 32'h20);
		for (int r = 1; r < 3; r++) begin
			xfer(32'(rcsm_pkg::REG_DIV0), 1'b1, 32'(r));
			tog(1, 400, c);
			chk(32'(c >= 40 / r - 2 && c <= 40 / r + 2), 32'h1, "post-divide");
		end
		$display("test banks done");
		close_out();
	end
endmodule : tb_ref_clock_switchover_monitor
`default_nettype wire
